// ### shared/wdit_pkg.sv
// Constants and state types of the watchdog and interval timer
package wdit_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] WDIT_IDX_COUNTER = 12'h084;
  localparam logic [11:0] WDIT_IDX_CONTROL = 12'h086;
  localparam logic [11:0] WDIT_IDX_LOWPOW  = 12'h088;

  // ----------------------------------------------------------------
  // Write keys, strobes, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WDIT_KEY_COUNTER = 8'h5a;
  localparam logic [7:0]  WDIT_KEY_CONTROL = 8'ha5;
  localparam logic [3:0]  WDIT_STRB_HALF   = 4'h3;
  localparam logic [7:0]  WDIT_RST_COUNTER = 8'h00;
  localparam logic [7:0]  WDIT_RST_CONTROL = 8'h00;
  localparam logic [7:0]  WDIT_CNT_LAST    = 8'hff;
  localparam logic [7:0]  WDIT_CNT_RELOCK  = 8'h7f;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int WDIT_BIT_RUN   = 7;
  localparam int WDIT_BIT_MODE  = 6;
  localparam int WDIT_BIT_RKIND = 5;
  localparam int WDIT_BIT_WATCHDOG_OVERFLOW_FLAG  = 4;
  localparam int WDIT_BIT_INTERVAL_OVERFLOW_FLAG  = 3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    WDIT_ST_NORMAL = 6'h01,
    WDIT_ST_SLEEP  = 6'h02,
    WDIT_ST_WAKE   = 6'h04,
    WDIT_ST_POST   = 6'h08,
    WDIT_ST_FREQ   = 6'h10,
    WDIT_ST_LOCKED = 6'h20
  } wdit_mode_t;

  typedef struct packed {
    wdit_mode_t  mode;
    logic [11:0] presc;
    logic [7:0]  counter;
    logic [7:0]  control;
    logic        low_power_select_bit;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        por_req;
    logic        manual_req;
    logic        irq_req;
    logic        clock_resume;
    logic        standby_reenter;
  } wdit_state_t;

endpackage : wdit_pkg

// ### logic/wdit_timer.sv
// Watchdog and interval timer with APB register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// Functional notes
// RULE1: Standby wake edge starts counting
// RULE2: Standby overflow resumes clock, no overflow flag
// RULE3: Keep counting; at 80 re-enter standby
// RULE4: Re-entered standby left only by power-on
// RULE5: Software clears run enable before standby
// RULE6: Software sets overflow time beyond settling
// RULE7: PLL rate write starts counter
// RULE8: Frequency overflow resumes clock, counter stops
// RULE9: Software checks counter zero before writing
// RULE10: Watchdog unused for divider-only changes
// RULE11: Software configures then sets run enable
// RULE12: Software rewrites counter to zero periodically
// RULE13: Watchdog overflow sets flag, issues reset
// RULE14: Interval overflow sets flag, requests interrupt
// RULE15: Reset exit of standby does not count
// RULE16: Change multiplier with cache off
// RULE17: Wait 30 bus clocks before cache
// RULE18: Keyed half-word writes, byte reads
// RULE19: Eight-bit counter, eight prescaler ratios
// RULE20: Reset kind: zero power-on, one manual
// RULE21: Overflow is FF to 00 wrap
module wdit_timer
  import wdit_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        standby_enter,
  input  wire logic        wake_event,
  input  wire logic        pll_rate_write,
  output logic             por_req,
  output logic             manual_req,
  output logic             interval_irq,
  output logic             clock_resume,
  output logic             standby_reenter
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdit_state_t s;
  wdit_state_t next_s;

  logic [11:0] div_mask;
  logic        tick;
  logic        counting;
  logic        ovf;
  logic        wr_done;
  logic        mapped;
  logic [11:0] idx;
  logic        cnt_wr;
  logic        ctl_wr;
  logic        lp_wr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s                 = s;
    next_s.presc           = s.presc + 12'h001;
    next_s.por_req         = 1'b0;
    next_s.manual_req      = 1'b0;
    next_s.irq_req         = 1'b0;
    next_s.clock_resume    = 1'b0;
    next_s.standby_reenter = 1'b0;

    case (s.control[2:0]) // [RULE19]
      3'h0:    div_mask = 12'h000;
      3'h1:    div_mask = 12'h003;
      3'h2:    div_mask = 12'h00f;
      3'h3:    div_mask = 12'h01f;
      3'h4:    div_mask = 12'h03f;
      3'h5:    div_mask = 12'h0ff;
      3'h6:    div_mask = 12'h3ff;
      default: div_mask = 12'hfff;
    endcase
    tick = ((s.presc & div_mask) == div_mask);

    counting = ((s.mode == WDIT_ST_NORMAL) && s.control[WDIT_BIT_RUN])
             || (s.mode == WDIT_ST_WAKE) || (s.mode == WDIT_ST_POST)
             || (s.mode == WDIT_ST_FREQ);
    ovf = counting && tick && (s.counter == WDIT_CNT_LAST); // [RULE21]

    idx     = paddr[13:2];
    mapped  = (paddr[31:14] == 18'h00000) && (paddr[1:0] == 2'h0)
            && ((idx == WDIT_IDX_COUNTER) || (idx == WDIT_IDX_CONTROL)
            || (idx == WDIT_IDX_LOWPOW));
    wr_done = psel && penable && s.pready && pwrite && mapped;
    cnt_wr  = wr_done && (idx == WDIT_IDX_COUNTER) && (pstrb == WDIT_STRB_HALF)
            && (pwdata[15:8] == WDIT_KEY_COUNTER); // [RULE18]
    ctl_wr  = wr_done && (idx == WDIT_IDX_CONTROL) && (pstrb == WDIT_STRB_HALF)
            && (pwdata[15:8] == WDIT_KEY_CONTROL); // [RULE18]
    lp_wr   = wr_done && (idx == WDIT_IDX_LOWPOW) && pstrb[0];

    // Counter: a keyed write beats the increment
    if (cnt_wr) begin
      next_s.counter = pwdata[7:0];
    end else if (counting && tick) begin
      next_s.counter = s.counter + 8'h01; // [RULE19] [RULE21]
    end

    // Control: flags may only be cleared by software, set wins
    if (ctl_wr) begin
      next_s.control = {pwdata[7:5], pwdata[4:3] & s.control[4:3], pwdata[2:0]};
    end
    if (lp_wr) begin
      next_s.low_power_select_bit = pwdata[0];
    end

    case (s.mode)
      WDIT_ST_NORMAL: begin
        if (ovf && s.control[WDIT_BIT_MODE]) begin
          next_s.control[WDIT_BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1; // [RULE13]
          next_s.por_req    = !s.control[WDIT_BIT_RKIND]; // [RULE20]
          next_s.manual_req = s.control[WDIT_BIT_RKIND]; // [RULE20]
        end else if (ovf) begin
          next_s.control[WDIT_BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1; // [RULE14]
          next_s.irq_req = 1'b1; // [RULE14]
        end
        if (pll_rate_write) begin
          next_s.mode = WDIT_ST_FREQ; // [RULE7]
        end else if (standby_enter) begin
          next_s.mode = WDIT_ST_SLEEP;
        end
      end
      WDIT_ST_SLEEP: begin
        if (wake_event) begin
          next_s.mode = WDIT_ST_WAKE; // [RULE1]
        end
      end
      WDIT_ST_WAKE: begin
        if (ovf) begin
          next_s.clock_resume = 1'b1; // [RULE2]
          next_s.mode         = WDIT_ST_POST; // [RULE3]
        end
      end
      WDIT_ST_POST: begin
        if (!s.low_power_select_bit) begin
          next_s.mode = WDIT_ST_NORMAL;
        end else if (tick && (s.counter == WDIT_CNT_RELOCK)) begin
          next_s.standby_reenter = 1'b1; // [RULE3]
          next_s.mode            = WDIT_ST_LOCKED;
        end
      end
      WDIT_ST_FREQ: begin
        if (ovf) begin
          next_s.clock_resume = 1'b1; // [RULE8]
          next_s.mode         = WDIT_ST_NORMAL; // [RULE8]
        end
      end
      WDIT_ST_LOCKED: begin
        next_s.mode = WDIT_ST_LOCKED; // [RULE4]
      end
      default: begin
        next_s.mode = WDIT_ST_NORMAL;
      end
    endcase

    // APB: answer registered in the setup cycle, zero wait states
    if (psel && !penable) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped;
      next_s.prdata  = 32'h00000000;
      if (idx == WDIT_IDX_COUNTER) begin
        next_s.prdata[7:0] = s.counter; // [RULE18]
      end else if (idx == WDIT_IDX_CONTROL) begin
        next_s.prdata[7:0] = s.control; // [RULE18]
      end else if (idx == WDIT_IDX_LOWPOW) begin
        next_s.prdata[1:0] = {(s.mode == WDIT_ST_LOCKED), s.low_power_select_bit};
      end
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{mode: WDIT_ST_NORMAL, presc: 12'h000, counter: WDIT_RST_COUNTER,
             control: WDIT_RST_CONTROL, prdata: 32'h00000000, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pready          = s.pready;
  assign prdata          = s.prdata;
  assign pslverr         = s.pslverr;
  assign por_req         = s.por_req;
  assign manual_req      = s.manual_req;
  assign interval_irq    = s.irq_req;
  assign clock_resume    = s.clock_resume;
  assign standby_reenter = s.standby_reenter;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wake_start_a: assert property ((s.mode == WDIT_ST_SLEEP) && wake_event // [RULE1]
    |=> s.mode == WDIT_ST_WAKE) else $error("wake did not start count");
  low_power_select_bit_resume_a: assert property ((s.mode == WDIT_ST_WAKE) && ovf // [RULE2]
    |=> clock_resume && !s.control[WDIT_BIT_WATCHDOG_OVERFLOW_FLAG] && s.counter == 8'h00)
    else $error("standby overflow wrong");
  relock_at80_a: assert property (standby_reenter // [RULE3]
    |-> s.counter == 8'h80 && s.mode == WDIT_ST_LOCKED) else $error("relock wrong");
  locked_stays_a: assert property ((s.mode == WDIT_ST_LOCKED) // [RULE4]
    |=> s.mode == WDIT_ST_LOCKED) else $error("locked standby left");
  pll_start_a: assert property ((s.mode == WDIT_ST_NORMAL) && pll_rate_write // [RULE7]
    |=> s.mode == WDIT_ST_FREQ) else $error("pll write ignored");
  freq_stop_a: assert property ((s.mode == WDIT_ST_FREQ) && ovf // [RULE8]
    |=> clock_resume && !s.control[WDIT_BIT_WATCHDOG_OVERFLOW_FLAG] && s.counter == 8'h00)
    else $error("frequency overflow wrong");
  wd_reset_a: assert property ((s.mode == WDIT_ST_NORMAL) && ovf // [RULE13]
    && s.control[WDIT_BIT_MODE] |=> s.control[WDIT_BIT_WATCHDOG_OVERFLOW_FLAG] && (por_req != manual_req)
    && manual_req == $past(s.control[WDIT_BIT_RKIND])) else $error("watchdog reset wrong");
  iv_irq_a: assert property ((s.mode == WDIT_ST_NORMAL) && ovf // [RULE14]
    && !s.control[WDIT_BIT_MODE] |=> interval_irq && s.control[WDIT_BIT_INTERVAL_OVERFLOW_FLAG]
    && !por_req && !manual_req) else $error("interval irq wrong");
  key_guard_a: assert property (wr_done && (idx == WDIT_IDX_CONTROL) // [RULE18]
    && pwdata[15:8] != WDIT_KEY_CONTROL && !ovf |=> $stable(s.control))
    else $error("unkeyed control write");

endmodule : wdit_timer

// ### sim/wdit_cpg_model.sv
// Clock generator and interrupt controller stand-in for the timer
`timescale 1ns/1ps
module wdit_cpg_model (
  input  wire logic pclk,
  input  wire logic clock_resume,
  input  wire logic standby_reenter,
  input  wire logic interval_irq,
  output logic      standby_enter,
  output logic      wake_event,
  output logic      pll_rate_write
);
  int   n_irq = 0;
  logic asleep = 1'b0;

  initial begin
    {standby_enter, wake_event, pll_rate_write} = 3'b000;
  end

  // Clock stopped from standby entry until a resume
  always @(posedge pclk) begin
    if (standby_enter || standby_reenter) begin
      asleep <= 1'b1;
    end else if (clock_resume) begin
      asleep <= 1'b0;
    end
    if (interval_irq) begin
      n_irq <= n_irq + 1;
    end
  end

  // 0 standby entry, 1 wake edge, 2 rate write
  task automatic pulse(input int kind);
    @(posedge pclk);
    if (kind == 0) begin
      standby_enter <= 1'b1;
    end else if (kind == 1 && asleep) begin
      wake_event <= 1'b1;
    end else if (kind == 2 && !asleep) begin
      pll_rate_write <= 1'b1;
    end
    @(posedge pclk);
    {standby_enter, wake_event, pll_rate_write} <= 3'b000;
  endtask : pulse
endmodule : wdit_cpg_model

// ### sim/tb_watchdog_interval_timer.sv
// Self-checking bench for the watchdog and interval timer
`timescale 1ns/1ps
module tb_watchdog_interval_timer import wdit_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic        por_req, manual_req, interval_irq, clock_resume, standby_reenter;
  logic        standby_enter, wake_event, pll_rate_write;
  logic [7:0]  rd, v;
  logic [4:0]  hit;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          sh[8] = '{0, 2, 4, 5, 6, 8, 10, 12};
  wire  [4:0]  ev = {por_req, manual_req, interval_irq, clock_resume, standby_reenter};

  wdit_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .standby_enter, .wake_event, .pll_rate_write, .por_req,
    .manual_req, .interval_irq, .clock_resume, .standby_reenter);
  wdit_cpg_model i_cpg (.pclk, .clock_resume, .standby_reenter, .interval_irq,
    .standby_enter, .wake_event, .pll_rate_write);

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] d,
                     input logic [3:0] st);
    int n;
    @(posedge pclk);
    {psel, pwrite, pstrb} <= {1'b1, wr, st};
    paddr  <= {18'h0, idx, 2'b00};
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Sample the answer at the rising edge that completes the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
    end
    err = pslverr;
    rd  = prdata[7:0];
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic wcnt(input logic [7:0] d);
    apb(1'b1, WDIT_IDX_COUNTER, {WDIT_KEY_COUNTER, d}, WDIT_STRB_HALF);
  endtask : wcnt

  task automatic wctl(input logic run, md, rk, input logic [2:0] s);
    apb(1'b1, WDIT_IDX_CONTROL, {WDIT_KEY_CONTROL, run, md, rk, 2'b00, s}, WDIT_STRB_HALF);
  endtask : wctl

  task automatic wait_ev(input logic [4:0] m, input int lim);
    hit = 5'h00;
    for (int i = 0; i < lim && hit == 5'h00; i++) begin
      @(negedge pclk);
      if ((ev & m) != 5'h00) hit = ev;
    end
  endtask : wait_ev

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    void'($urandom(59873));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, WDIT_IDX_CONTROL, 16'h0, 4'h0);
    check("ctl_reset", rd, WDIT_RST_CONTROL);
    check("mapped_ok", err, 1'b0);
    v = 8'($urandom());
    apb(1'b1, WDIT_IDX_COUNTER, {WDIT_KEY_CONTROL, v}, WDIT_STRB_HALF);
    apb(1'b1, WDIT_IDX_COUNTER, {WDIT_KEY_COUNTER, v}, 4'hf);
    apb(1'b0, WDIT_IDX_COUNTER, 16'h0, 4'h0);
    check("cnt_refused", rd, WDIT_RST_COUNTER);
    apb(1'b1, WDIT_IDX_CONTROL, {WDIT_KEY_COUNTER, 8'he7}, WDIT_STRB_HALF);
    apb(1'b0, WDIT_IDX_CONTROL, 16'h0, 4'h0);
    check("ctl_refused", rd, WDIT_RST_CONTROL);
    wcnt(v);
    apb(1'b0, WDIT_IDX_COUNTER, 16'h0, 4'h0);
    check("cnt_written", rd, v);
    apb(1'b0, 12'h0ff, 16'h0, 4'h0);
    check("unmapped_err", err, 1'b1);
    // Interval mode at every count clock ratio
    for (int s = 0; s < 8; s++) begin
      wctl(1'b0, 1'b0, 1'b0, s[2:0]);
      wcnt(WDIT_CNT_LAST);
      wctl(1'b1, 1'b0, 1'b0, s[2:0]);
      wait_ev(5'h1f, (1 << sh[s]) + 8);
      check("irq_hit", hit, 5'h04);
      apb(1'b0, WDIT_IDX_CONTROL, 16'h0, 4'h0);
      check("interval_overflow_flag_set", rd & 8'h18, 8'h08);
      wctl(1'b0, 1'b0, 1'b0, 3'h0);
    end
    check("irq_count", i_cpg.n_irq, 32'd8);
    // Watchdog mode with both reset kinds
    for (int k = 0; k < 2; k++) begin
      wctl(1'b0, 1'b1, k[0], 3'h0);
      wcnt(8'hfe);
      wctl(1'b1, 1'b1, k[0], 3'h0);
      wait_ev(5'h1f, 12);
      check("reset_kind", hit, k ? 5'h08 : 5'h10);
      apb(1'b0, WDIT_IDX_CONTROL, 16'h0, 4'h0);
      check("watchdog_overflow_flag_set", rd & 8'h18, 8'h10);
      wctl(1'b0, 1'b0, 1'b0, 3'h0);
    end
    // Rate change settling
    wcnt(8'hfe);
    i_cpg.pulse(2);
    wait_ev(5'h1f, 40);
    check("freq_resume", hit, 5'h02);
    repeat (30) @(posedge pclk);
    apb(1'b0, WDIT_IDX_COUNTER, 16'h0, 4'h0);
    check("freq_stop", rd[7:1], 7'h00);
    apb(1'b0, WDIT_IDX_CONTROL, 16'h0, 4'h0);
    check("freq_noflag", rd, 8'h00);
    // Standby exit, relock and power-on release
    wcnt(8'hfe);
    apb(1'b1, WDIT_IDX_LOWPOW, 16'h0001, 4'hf);
    i_cpg.pulse(0);
    apb(1'b0, WDIT_IDX_COUNTER, 16'h0, 4'h0);
    check("sleep_hold", rd, 8'hfe);
    i_cpg.pulse(1);
    wait_ev(5'h1f, 40);
    check("wake_resume", hit, 5'h02);
    apb(1'b0, WDIT_IDX_CONTROL, 16'h0, 4'h0);
    check("wake_noflag", rd, 8'h00);
    wait_ev(5'h1f, 200);
    check("relock", hit, 5'h01);
    i_cpg.pulse(1);
    wait_ev(5'h1f, 300);
    check("locked_stay", hit, 5'h00);
    apb(1'b0, WDIT_IDX_LOWPOW, 16'h0, 4'h0);
    check("lock_bit", rd[1], 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, WDIT_IDX_LOWPOW, 16'h0, 4'h0);
    check("lock_cleared", rd, 8'h00);
    apb(1'b0, WDIT_IDX_COUNTER, 16'h0, 4'h0);
    check("cnt_por", rd, WDIT_RST_COUNTER);
    finish_test();
  end
endmodule : tb_watchdog_interval_timer
